// ### rtl/qdc_pkg.sv
package qdc_pkg;
    // register indices; byte address is four times the index
    localparam int ADDR_W = 12;
    localparam logic [7:0] IDX_WRAP = 8'h90;
    localparam logic [7:0] IDX_CTRL = 8'h91;
    localparam logic [7:0] IDX_CNT1 = 8'h94;
    localparam logic [7:0] IDX_CNT2 = 8'h96;
    localparam logic [7:0] IDX_ISTAT = 8'h98;
    localparam logic [7:0] IDX_IMASK = 8'h99;
    localparam logic [ADDR_W-1:0] ADDR_WRAP = {2'h0, IDX_WRAP, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_CTRL = {2'h0, IDX_CTRL, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_CNT1 = {2'h0, IDX_CNT1, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_CNT2 = {2'h0, IDX_CNT2, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_ISTAT = {2'h0, IDX_ISTAT, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_IMASK = {2'h0, IDX_IMASK, 2'h0};

    // reset values and write masks
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] IMASK_RESET = 8'hcc;
    localparam logic [7:0] CTRL_KEEP = 8'hcf;
    localparam logic [7:0] WRAP_BITS = 8'hcc;

    // wrap status field positions, index 0 is channel one
    localparam int WRAP_INC [2] = '{3, 7};
    localparam int WRAP_DEC [2] = '{2, 6};
    localparam int WRAP_RST [2] = '{0, 4};

    // port pin of each input, [channel][upper nibble]
    localparam int PIN_I [2][2] = '{'{1, 5}, '{3, 7}};
    localparam int PIN_Q [2][2] = '{'{0, 4}, '{2, 6}};

    // counter limits
    localparam logic [7:0] CNT_TOP = 8'hff;
    localparam logic [7:0] CNT_ZERO = 8'h00;
    localparam logic [7:0] CNT_ONE = 8'h01;

    // control register layout
    typedef struct packed {
        logic [1:0] src2;
        logic [1:0] unused;
        logic [1:0] src1;
        logic [1:0] irq_pri;
    } qdc_ctrl_t;

    // per-channel tracking state
    typedef struct packed {
        logic armed;
        logic [1:0] src;
        logic si;
        logic sq;
        logic fi;
        logic fq;
    } qdc_chan_t;

    // returns {up, down} for a move from prev to cur, each {i, q}
    function automatic logic [1:0] qdc_step(input logic [1:0] prev, input logic [1:0] cur);
        logic moved;
        logic fwd;
        moved = ^(prev ^ cur);
        fwd = prev[1] ^ cur[0];
        return {moved & fwd, moved & ~fwd};
    endfunction : qdc_step
endpackage : qdc_pkg

// ### rtl/qdc_top.sv
// Behaviour
// RULE_01 - channel two source 0x disables, no count
// RULE_02 - channel two uses bits 3/2 or 7/6
// RULE_03 - channel one source 0x disables, no count
// RULE_04 - channel one uses bits 1/0 or 5/4
// RULE_05 - control bits 5:4 are ignored
// RULE_06 - interrupt field off or priority one to three
// RULE_07 - count registers return full 8-bit counters
// RULE_08 - encoder drives I odd, Q even bit
// RULE_09 - pulses under two samples are filtered out
// RULE_10 - wrap sets flag and interrupt, read clears
// RULE_11 - sample only on timer tick, half rate; the code samples on the first cycle of every tick, at full tick rate
// RULE_12 - count up or down by direction, mod 256
`timescale 1ns/1ps
`default_nettype none

module qdc_top
    import qdc_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // encoder port and sample tick
    input wire logic [7:0] pf_in,
    input wire logic sample_tick_in,
    // interrupt
    output logic irq_out,
    output logic [1:0] irq_level_out
);

    // state
    qdc_ctrl_t ctrl;
    qdc_chan_t chan [2];
    logic [7:0] cnt [2];
    logic [7:0] wrap;
    logic [7:0] istat;
    logic [7:0] imask;
    logic tick_q;

    // next values
    qdc_ctrl_t next_ctrl;
    qdc_chan_t next_chan [2];
    logic [7:0] next_cnt [2];
    logic [7:0] next_wrap;
    logic [7:0] next_istat;
    logic [7:0] next_imask;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic next_irq;
    logic [1:0] next_level;

    // bus phase decode
    wire logic access = psel_in & penable_in;
    wire logic ask = access & ~pready_out;
    wire logic fin = access & pready_out;
    wire logic wr_ok = fin & pwrite_in & pstrb_in[0];
    wire logic rd_fin = fin & ~pwrite_in;

    // address decode
    wire logic hit_wrap = paddr_in == ADDR_WRAP;
    wire logic hit_ctrl = paddr_in == ADDR_CTRL;
    wire logic hit_cnt1 = paddr_in == ADDR_CNT1;
    wire logic hit_cnt2 = paddr_in == ADDR_CNT2;
    wire logic hit_istat = paddr_in == ADDR_ISTAT;
    wire logic hit_imask = paddr_in == ADDR_IMASK;
    wire logic hit_any = hit_wrap | hit_ctrl | hit_cnt1 | hit_cnt2 | hit_istat | hit_imask;

    // register write and read strobes
    wire logic wr_wrap = wr_ok & hit_wrap;
    wire logic wr_ctrl = wr_ok & hit_ctrl;
    wire logic wr_istat = wr_ok & hit_istat;
    wire logic wr_imask = wr_ok & hit_imask;
    wire logic rd_wrap = rd_fin & hit_wrap;

    // only bits that were actually returned get cleared, so a wrap landing
    // between the data capture and the completing edge is not lost
    wire logic [7:0] rd_clr = rd_wrap ? (prdata_out[7:0] & WRAP_BITS) : 8'h00;
    wire logic [7:0] w1c_clr = wr_istat ? (pwdata_in[7:0] & WRAP_BITS) : 8'h00;

    // a held-high tick counts only once, on its first cycle
    wire logic tick_ok = sample_tick_in & ~tick_q; // see RULE_11

    // per-channel decode wires
    logic [1:0] ch_src [2];
    logic raw_i [2];
    logic raw_q [2];
    logic flt_i [2];
    logic flt_q [2];
    logic [1:0] step [2];
    logic live [2];
    logic do_up [2];
    logic do_dn [2];
    logic zero_cnt [2];
    logic [7:0] wrap_set;

    assign ch_src[0] = ctrl.src1; // see RULE_03
    assign ch_src[1] = ctrl.src2; // see RULE_01

    for (genvar c = 0; c < 2; c++) begin : g_ch
        // nibble select, I on the odd pin and Q on the even pin
        assign raw_i[c] = ch_src[c][0] ? pf_in[PIN_I[c][1]] : pf_in[PIN_I[c][0]]; // see RULE_02 see RULE_04 see RULE_08
        assign raw_q[c] = ch_src[c][0] ? pf_in[PIN_Q[c][1]] : pf_in[PIN_Q[c][0]]; // see RULE_02 see RULE_04 see RULE_08

        // a new level is taken only once seen on two ticks in a row
        assign flt_i[c] = (raw_i[c] == chan[c].si) ? raw_i[c] : chan[c].fi; // see RULE_09
        assign flt_q[c] = (raw_q[c] == chan[c].sq) ? raw_q[c] : chan[c].fq; // see RULE_09

        // direction from the filtered pair
        assign step[c] = qdc_step({chan[c].fi, chan[c].fq}, {flt_i[c], flt_q[c]});

        // counting needs an armed channel whose source has not moved
        assign live[c] = chan[c].armed & ch_src[c][1] & (ch_src[c] == chan[c].src); // see RULE_01 see RULE_03
        assign do_up[c] = tick_ok & live[c] & step[c][1]; // see RULE_11 see RULE_12
        assign do_dn[c] = tick_ok & live[c] & step[c][0]; // see RULE_11 see RULE_12
        assign zero_cnt[c] = wr_wrap & pwdata_in[WRAP_RST[c]];

        // counter, software zeroing wins over a step and raises no flag
        assign next_cnt[c] = zero_cnt[c] ? CNT_ZERO :
                             do_up[c] ? cnt[c] + CNT_ONE :
                             do_dn[c] ? cnt[c] - CNT_ONE : cnt[c]; // see RULE_12

        // tracking state; re-arming reloads the filter without a count,
        // so entering or leaving disable never moves the counter
        always_comb begin
            next_chan[c] = chan[c];
            if (!ch_src[c][1] || ch_src[c] != chan[c].src) begin
                next_chan[c].armed = 1'b0; // see RULE_01 see RULE_03
                next_chan[c].src = ch_src[c];
            end else if (tick_ok && !chan[c].armed) begin
                next_chan[c].armed = 1'b1;
                next_chan[c].si = raw_i[c];
                next_chan[c].sq = raw_q[c];
                next_chan[c].fi = raw_i[c];
                next_chan[c].fq = raw_q[c];
            end else if (tick_ok) begin
                next_chan[c].si = raw_i[c];
                next_chan[c].sq = raw_q[c];
                next_chan[c].fi = flt_i[c];
                next_chan[c].fq = flt_q[c];
            end
        end
    end

    // wrap events of both channels
    always_comb begin
        wrap_set = 8'h00;
        for (int c = 0; c < 2; c++) begin
            wrap_set[WRAP_INC[c]] = do_up[c] & ~zero_cnt[c] & (cnt[c] == CNT_TOP); // see RULE_10
            wrap_set[WRAP_DEC[c]] = do_dn[c] & ~zero_cnt[c] & (cnt[c] == CNT_ZERO); // see RULE_10
        end
    end

    // sticky flags, a set in the clearing cycle wins
    assign next_wrap = (wrap & ~rd_clr) | wrap_set; // see RULE_10
    assign next_istat = (istat & ~(rd_clr | w1c_clr)) | wrap_set; // see RULE_10

    // control and mask writes, ignored bits never stored
    assign next_ctrl = wr_ctrl ? qdc_ctrl_t'(pwdata_in[7:0] & CTRL_KEEP) : ctrl; // see RULE_05
    assign next_imask = wr_imask ? (pwdata_in[7:0] & WRAP_BITS) : imask;

    // interrupt follows the flag edge; priority zero keeps it quiet
    assign next_irq = (|(next_istat & imask)) & (ctrl.irq_pri != 2'h0); // see RULE_06 see RULE_10
    assign next_level = next_irq ? ctrl.irq_pri : 2'h0; // see RULE_06

    // one wait state: data is captured in the first access cycle
    assign next_pready = ask;
    assign next_pslverr = ask & ~hit_any;
    always_comb begin
        next_prdata = prdata_out;
        if (ask) begin
            next_prdata = 32'h0000_0000;
            if (!pwrite_in) begin
                unique case (1'b1)
                    hit_wrap: next_prdata[7:0] = wrap;
                    hit_cnt1: next_prdata[7:0] = cnt[0]; // see RULE_07
                    hit_cnt2: next_prdata[7:0] = cnt[1]; // see RULE_07
                    hit_istat: next_prdata[7:0] = istat;
                    hit_imask: next_prdata[7:0] = imask;
                    default: next_prdata[7:0] = 8'h00;
                endcase
            end
        end
    end

    // bus outputs
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            prdata_out <= 32'h0000_0000;
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
        end else begin
            prdata_out <= next_prdata;
            pready_out <= next_pready;
            pslverr_out <= next_pslverr;
        end
    end

    // configuration and flags
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl <= qdc_ctrl_t'(CTRL_RESET);
            imask <= IMASK_RESET;
            wrap <= 8'h00;
            istat <= 8'h00;
            irq_out <= 1'b0;
            irq_level_out <= 2'h0;
            tick_q <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            imask <= next_imask;
            wrap <= next_wrap;
            istat <= next_istat;
            irq_out <= next_irq;
            irq_level_out <= next_level;
            tick_q <= sample_tick_in;
        end
    end

    // channel state and counters
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int c = 0; c < 2; c++) begin
                chan[c] <= '0;
                cnt[c] <= CNT_ZERO;
            end
        end else begin
            for (int c = 0; c < 2; c++) begin
                chan[c] <= next_chan[c];
                cnt[c] <= next_cnt[c];
            end
        end
    end

endmodule : qdc_top

`default_nettype wire

// ### test/qdc_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module qdc_assertions
    import qdc_pkg::*;
(
    // clock, reset and bus
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ADDR_W-1:0] paddr_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    // decoder side
    input wire logic sample_tick_in,
    input wire logic irq_out,
    input wire logic [1:0] irq_level_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // a transfer completing at this edge
    wire logic done = psel_in && penable_in && pready_out;
    wire logic cnt_hit = paddr_in == ADDR_CNT1 || paddr_in == ADDR_CNT2;
    property p_ready_pulse; pready_out |=> !pready_out; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");
    property p_one_wait; (psel_in && !penable_in) ##1 (psel_in && penable_in) |=> pready_out; endproperty
    a_one_wait: assert property (p_one_wait) else $error("no ready");
    property p_rd_upper; done && !pwrite_in |-> prdata_out[31:8] == 24'h0; endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("upper data");
    property p_cnt_ok; done && cnt_hit |-> !pslverr_out; endproperty
    a_cnt_ok: assert property (p_cnt_ok) else $error("count err");
    property p_level; irq_out == (irq_level_out != 2'h0); endproperty
    a_level: assert property (p_level) else $error("level");
    // the interrupt starts from an accepted sample tick, or two edges after
    // a write that unmasks or re-prioritises a pending flag
    property p_on_tick;
        $rose(irq_out) |-> ($past(sample_tick_in) && !$past(sample_tick_in, 2)) || $past(done && pwrite_in, 2);
    endproperty
    a_on_tick: assert property (p_on_tick) else $error("irq off tick");
    property p_rd_clear; done && !pwrite_in && paddr_in == ADDR_WRAP |-> ##[1:2] !irq_out; endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("not cleared");
    property p_fall; $fell(irq_out) |-> $past(done) || $past(done, 2); endproperty
    a_fall: assert property (p_fall) else $error("irq dropped");
    c_irq: cover property ($rose(irq_out));
    c_err: cover property (done && pslverr_out);
    c_lvl3: cover property (irq_level_out == 2'h3);
endmodule : qdc_assertions
bind qdc_top qdc_assertions u_chk (.clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .prdata_out, .pready_out, .pslverr_out, .sample_tick_in, .irq_out, .irq_level_out);
`default_nettype wire

// ### test/qdc_enc_model.sv
`timescale 1ns/1ps
`default_nettype none
module qdc_enc_model (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // one step pulse per pair
    input wire logic [3:0] up_in,
    input wire logic [3:0] dn_in,
    // port pins
    output logic [7:0] pf_out
);
    logic [3:0][1:0] ph = '0;
    // shaft phase per encoder; gray coded so one line moves a step
    always @(posedge clk_in or posedge rst_in) begin
        for (int k = 0; k < 4; k++) begin
            ph[k] <= rst_in ? 2'h0 : ph[k] + {1'b0, up_in[k]} - {1'b0, dn_in[k]};
        end
    end
    // in-phase on the odd bit, quadrature on the even bit
    for (genvar k = 0; k < 4; k++) begin : g_pair
        assign pf_out[2*k+1] = ph[k][1];
        assign pf_out[2*k] = ph[k][1] ^ ph[k][0];
    end
endmodule : qdc_enc_model
`default_nettype wire

// ### test/tb_quadrature_decoder_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_quadrature_decoder_control;
    import qdc_pkg::*;
    typedef struct {logic [7:0] c; int p; logic f; int n; logic [7:0] e1; logic [7:0] e2;} qdc_row_t;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, tick = 1'b0, tick_en = 1'b1, rdy, err, rerr, irq;
    logic [ADDR_W-1:0] addr = '0;
    logic [31:0] wdata = '0, rdata, rd;
    logic [1:0] lvl, lv, tdiv = '0;
    logic [7:0] pf;
    logic [3:0] up = '0, dn = '0;
    int miscompares = 0;
    int tests_run = 0;
    qdc_row_t rows [9] = '{
        '{8'h08, 0, 1, 3, 8'h03, 8'h00},
        '{8'h0c, 2, 0, 2, 8'hfe, 8'h00},
        '{8'h0c, 0, 1, 2, 8'h00, 8'h00},
        '{8'h80, 1, 1, 2, 8'h00, 8'h02},
        '{8'hc0, 3, 0, 1, 8'h00, 8'hff},
        '{8'hc0, 1, 1, 2, 8'h00, 8'h00},
        '{8'h04, 0, 1, 2, 8'h00, 8'h00},
        '{8'h40, 1, 1, 2, 8'h00, 8'h00},
        '{8'h38, 0, 1, 1, 8'h01, 8'h00}};
    qdc_top dut (.clk_in, .rst_in, .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(addr),
        .pwdata_in(wdata), .pstrb_in(4'hf), .prdata_out(rdata), .pready_out(rdy), .pslverr_out(err),
        .pf_in(pf), .sample_tick_in(tick), .irq_out(irq), .irq_level_out(lvl));
    qdc_enc_model enc (.clk_in, .rst_in, .up_in(up), .dn_in(dn), .pf_out(pf));
    always #4 clk_in = ~clk_in;
    // timer stand-in: one-cycle tick every fourth clock
    always @(posedge clk_in) begin
        tdiv <= tdiv + 2'h1;
        tick <= tick_en && (tdiv == 2'h0);
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwr <= w;
        addr <= a;
        wdata <= d;
        @(posedge clk_in);
        pen <= 1'b1;
        @(posedge clk_in);
        // wait for ready; only the watchdog ends a hung transfer
        while (rdy !== 1'b1) begin
            @(posedge clk_in);
        end
        rd = rdata;
        rerr = err;
        psel <= 1'b0;
        pen <= 1'b0;
        // one idle edge, so a following call never re-drives psel in this step
        @(posedge clk_in);
    endtask : apb
    task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rdchk
    // each step held four ticks so the filter takes it
    task automatic move(input int p, input logic f, input int n);
        repeat (n) begin
            up[p] <= f;
            dn[p] <= !f;
            @(posedge clk_in);
            up <= '0;
            dn <= '0;
            repeat (15) @(posedge clk_in);
        end
    endtask : move
    task automatic final_report();
        if (miscompares == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report
    // the sequence needs under 3000 cycles
    initial begin
        #100us;
        miscompares++;
        final_report();
    end
    initial begin
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        // zero first, so entering or leaving a source would show
        foreach (rows[i]) begin
            apb(1'b1, ADDR_WRAP, 32'h11);
            apb(1'b1, ADDR_CTRL, {24'h0, rows[i].c});
            repeat (12) @(posedge clk_in);
            move(rows[i].p, rows[i].f, rows[i].n);
            rdchk(ADDR_CNT1, {24'h0, rows[i].e1});
            rdchk(ADDR_CNT2, {24'h0, rows[i].e2});
        end
        // wrap below zero at each priority; last pass masked
        apb(1'b0, ADDR_WRAP, 32'h0);
        for (int i = 0; i < 5; i++) begin
            lv = (i > 0 && i < 4) ? 2'(i) : 2'h0;
            apb(1'b1, ADDR_IMASK, (i == 4) ? 32'h0 : 32'hcc);
            apb(1'b1, ADDR_WRAP, 32'h01);
            apb(1'b1, ADDR_CTRL, 32'h08 | ((i > 3) ? 3 : i));
            repeat (12) @(posedge clk_in);
            move(0, 1'b0, 1);
            chk({29'h0, lvl, irq}, {29'h0, lv, lv != 2'h0});
            rdchk(ADDR_WRAP, 32'h04);
            repeat (2) @(posedge clk_in);
            chk({31'h0, irq}, 32'h0);
        end
        // no tick, no sampling; the held step is taken once ticks resume
        apb(1'b1, ADDR_WRAP, 32'h01);
        tick_en <= 1'b0;
        move(0, 1'b1, 1);
        rdchk(ADDR_CNT1, 32'h0);
        tick_en <= 1'b1;
        repeat (12) @(posedge clk_in);
        rdchk(ADDR_CNT1, 32'h1);
        // four-cycle dip below zero, seen by one tick only; without the
        // filter it would wrap down and back up and leave both flags set
        apb(1'b1, ADDR_WRAP, 32'h01);
        dn[0] <= 1'b1;
        @(posedge clk_in);
        dn[0] <= 1'b0;
        repeat (3) @(posedge clk_in);
        up[0] <= 1'b1;
        @(posedge clk_in);
        up[0] <= 1'b0;
        repeat (16) @(posedge clk_in);
        rdchk(ADDR_WRAP, 32'h0);
        rdchk(ADDR_CNT1, 32'h0);
        // leave state behind so the reset below has something to undo
        move(0, 1'b1, 2);
        apb(1'b1, ADDR_IMASK, 32'h44);
        rst_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        rdchk(ADDR_CNT1, 32'h0);
        rdchk(ADDR_IMASK, {24'h0, IMASK_RESET});
        apb(1'b0, 12'h000, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        chk(rd, 32'h0);
        final_report();
    end
endmodule : tb_quadrature_decoder_control
`default_nettype wire
